// [logic/adc_fifo_ctrl.sv]
// analog input control: mux entry, conversion start, result fifo, flags, wishbone slave
// How it works
// - channel number comes from mux_entry bits seven to four.
// - gain code comes from mux_entry bits three to one.
// - committed channel and gain stay until the host loads a new entry or clears the mux.
// - writing zero to sw_convert_strobe starts exactly one conversion.
// - low pulse on ext_convert_n starts one conversion.
// - each finished conversion is pushed into the fifo automatically.
// - status bit 13 fifo_not_empty is set while results are stored.
// - status register reads as one 16-bit value.
// - reading fifo data pops the oldest result; flag drops on last.
// - reading an empty fifo returns zero; host checks flag first.
// - fifo_not_empty rises about five microseconds after a start.
// - fifo holds 256; extra results are lost, overflow flag low until clear.
// - start during a conversion pulls overrun flag low until clear.
// - unipolar_select picks straight binary or two's complement results.
// - unipolar results are straight binary 0 to 4095.
// - bipolar results are two's complement -2048 to +2047.
// - adc_clear_strobe clears error flags, fifo and acquisition_done.
`timescale 1ns/1ps
`default_nettype none
module adc_fifo_ctrl
  import adc_ctrl_pkg::*;
#(
  parameter int unsigned DEPTH = adc_ctrl_pkg::FIFO_DEPTH,
  parameter int unsigned CONV_CYC = adc_ctrl_pkg::CONV_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [adc_ctrl_pkg::ADDR_W-1:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // external trigger
  input wire logic i_ext_convert_n,
  // converter side
  input wire logic [adc_ctrl_pkg::SAMPLE_W-1:0] i_adc_data,
  output logic o_adc_start,
  output logic [3:0] o_adc_channel,
  output logic [2:0] o_adc_gain
);
  import adc_ctrl_pkg::*;

  localparam int unsigned AGE_W = $clog2(CONV_CYC + 2);
  localparam logic [AGE_W-1:0] AGE_DONE = AGE_W'(CONV_CYC);
  result_fifo_if #(.W(WORD_W), .DEPTH(DEPTH)) fif ();

  function automatic logic [WORD_W-1:0] fmt_sample(input logic [SAMPLE_W-1:0] raw, input logic unip);
    logic [WORD_W-1:0] v;
    v = {{(WORD_W - SAMPLE_W){1'b0}}, raw};
    if (!unip) begin
      v = {{(WORD_W - SAMPLE_W){~raw[SIGN_BIT]}}, ~raw[SIGN_BIT], raw[SIGN_BIT-1:0]};
    end
    return v;
  endfunction : fmt_sample

  // state
  logic ack_r, ack_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic [7:0] entry_r, entry_nxt;
  logic [7:0] mux_r, mux_nxt;
  logic unip_r, unip_nxt;
  logic ovf_n_r, ovf_n_nxt;
  logic ovr_n_r, ovr_n_nxt;
  logic acq_r, acq_nxt;
  logic ext_prev_r, ext_prev_nxt;
  logic start_r, start_nxt;
  logic [3:0] chan_r, chan_nxt;
  logic [2:0] gain_r, gain_nxt;
  logic [AGE_W-1:0] age_r, age_nxt;
  // decode
  logic req, wr, rd, wr_lo, clr, conv_sw, ext_fall, start;
  logic busy, done, overrun;
  logic [15:0] status;

  conv_sequencer #(.CYCLES(CONV_CYC)) u_seq (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_start(start),
    .o_busy(busy),
    .o_done(done),
    .o_overrun(overrun)
  );

  result_fifo #(.W(WORD_W), .DEPTH(DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .f(fif)
  );

  always_comb begin
    req = i_wb_cyc && i_wb_stb && !ack_r;
    wr = req && i_wb_we;
    rd = req && !i_wb_we;
    wr_lo = wr && i_wb_sel[0];
    clr = wr && (i_wb_adr == OFS_ADC_CLEAR);
    conv_sw = wr && (i_wb_adr == OFS_SW_CONVERT) && (i_wb_dat[15:0] == 16'h0000);
    ext_fall = ext_prev_r && !i_ext_convert_n;
    start = conv_sw || ext_fall;
    status = 16'h0000;
    status[ST_NOT_EMPTY] = !fif.empty;
    status[ST_OVERFLOW_N] = ovf_n_r;
    status[ST_OVERRUN_N] = ovr_n_r;
    status[ST_ACQ_DONE] = acq_r;
    status[ST_BUSY] = busy;
    fif.push = done;
    fif.wdata = fmt_sample(i_adc_data, unip_r);
    fif.pop = rd && (i_wb_adr == OFS_FIFO_DATA);
    fif.clear = clr;
  end

  always_comb begin
    ack_nxt = req;
    rd_nxt = RDATA_RST;
    entry_nxt = entry_r;
    mux_nxt = mux_r;
    unip_nxt = unip_r;
    ext_prev_nxt = i_ext_convert_n;
    start_nxt = start && !busy;
    ovf_n_nxt = ovf_n_r;
    ovr_n_nxt = ovr_n_r;
    acq_nxt = acq_r;
    if (clr) begin
      ovf_n_nxt = 1'b1;
      ovr_n_nxt = 1'b1;
      acq_nxt = 1'b0;
    end
    if (done && fif.full && !fif.pop && !clr) begin
      ovf_n_nxt = 1'b0;
    end
    if (overrun) begin
      ovr_n_nxt = 1'b0;
    end
    if (done) begin
      acq_nxt = 1'b1;
    end
    if (wr_lo && (i_wb_adr == OFS_MUX_ENTRY)) begin
      entry_nxt = i_wb_dat[7:0];
    end
    if (wr && (i_wb_adr == OFS_MUX_CLEAR)) begin
      mux_nxt = MUX_RST;
    end
    if (wr && (i_wb_adr == OFS_MUX_LOAD)) begin
      mux_nxt = entry_r;
    end
    if (wr_lo && (i_wb_adr == OFS_CONFIG)) begin
      unip_nxt = i_wb_dat[CFG_UNIPOLAR];
    end
    if (rd) begin
      unique case (i_wb_adr)
        OFS_MUX_ENTRY: rd_nxt = {24'h00_0000, entry_r};
        OFS_CONFIG: rd_nxt = {31'h0000_0000, unip_r};
        OFS_STATUS: rd_nxt = {16'h0000, status};
        OFS_FIFO_DATA: rd_nxt = fif.empty ? RDATA_RST : {16'h0000, fif.rdata};
        default: rd_nxt = RDATA_RST;
      endcase
    end
    chan_nxt = mux_r[CHAN_HI:CHAN_LO];
    gain_nxt = mux_r[GAIN_HI:GAIN_LO];
    age_nxt = age_r;
    if (start && !busy) begin
      age_nxt = AGE_W'(1);
    end else if (busy && (age_r != AGE_DONE)) begin
      age_nxt = age_r + AGE_W'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      ack_r <= 1'b0;
      rd_r <= RDATA_RST;
      entry_r <= MUX_RST;
      mux_r <= MUX_RST;
      unip_r <= CFG_UNIPOLAR_RST;
      ovf_n_r <= 1'b1;
      ovr_n_r <= 1'b1;
      acq_r <= 1'b0;
      ext_prev_r <= 1'b1;
      start_r <= 1'b0;
      chan_r <= 4'h0;
      gain_r <= 3'h0;
      age_r <= '0;
    end else begin
      ack_r <= ack_nxt;
      rd_r <= rd_nxt;
      entry_r <= entry_nxt;
      mux_r <= mux_nxt;
      unip_r <= unip_nxt;
      ovf_n_r <= ovf_n_nxt;
      ovr_n_r <= ovr_n_nxt;
      acq_r <= acq_nxt;
      ext_prev_r <= ext_prev_nxt;
      start_r <= start_nxt;
      chan_r <= chan_nxt;
      gain_r <= gain_nxt;
      age_r <= age_nxt;
    end
  end

  assign o_wb_ack = ack_r;
  assign o_wb_dat = rd_r;
  assign o_adc_start = start_r;
  assign o_adc_channel = chan_r;
  assign o_adc_gain = gain_r;

  property p_sw_start;
    @(posedge i_clk) disable iff (!i_rstn)
      (conv_sw && !busy && !ext_fall) |=> (o_adc_start && busy);
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("software strobe did not start conversion");

  property p_ext_start;
    @(posedge i_clk) disable iff (!i_rstn)
      (ext_fall && !busy) |=> o_adc_start;
  endproperty
  a_ext_start: assert property (p_ext_start) else $error("external pulse did not start conversion");

  property p_not_empty_after_start;
    @(posedge i_clk) disable iff (!i_rstn)
      done |-> (age_r == AGE_DONE);
  endproperty
  a_not_empty_after_start: assert property (p_not_empty_after_start) else $error("result pushed at wrong time");

  property p_done_timing;
    @(posedge i_clk) disable iff (!i_rstn)
      (start && !busy) |-> ##[1:1000] done;
  endproperty
  a_done_timing: assert property (p_done_timing) else $error("conversion result never arrived");

  property p_push_sets_flag;
    @(posedge i_clk) disable iff (!i_rstn)
      (done && !clr) |=> status[ST_NOT_EMPTY];
  endproperty
  a_push_sets_flag: assert property (p_push_sets_flag) else $error("fifo_not_empty not set after push");

  property p_overflow_sticky;
    @(posedge i_clk) disable iff (!i_rstn)
      (!ovf_n_r && !clr) |=> !ovf_n_r;
  endproperty
  a_overflow_sticky: assert property (p_overflow_sticky) else $error("overflow flag released without clear");

  property p_overrun_flag;
    @(posedge i_clk) disable iff (!i_rstn)
      (start && busy) |=> !ovr_n_r;
  endproperty
  a_overrun_flag: assert property (p_overrun_flag) else $error("overrun not flagged");

  property p_clear_flags;
    @(posedge i_clk) disable iff (!i_rstn)
      (clr && !done && !overrun) |=> (ovf_n_r && ovr_n_r && !acq_r && fif.empty);
  endproperty
  a_clear_flags: assert property (p_clear_flags) else $error("clear strobe left state behind");

  property p_mux_hold;
    @(posedge i_clk) disable iff (!i_rstn)
      !(wr && ((i_wb_adr == OFS_MUX_LOAD) || (i_wb_adr == OFS_MUX_CLEAR))) |=> (mux_r == $past(mux_r));
  endproperty
  a_mux_hold: assert property (p_mux_hold) else $error("mux selection changed without load");

  property p_chan_out;
    @(posedge i_clk) disable iff (!i_rstn)
      ##1 (o_adc_channel == $past(mux_r[CHAN_HI:CHAN_LO])) && (o_adc_gain == $past(mux_r[GAIN_HI:GAIN_LO]));
  endproperty
  a_chan_out: assert property (p_chan_out) else $error("channel or gain output wrong");

  property p_format;
    @(posedge i_clk) disable iff (!i_rstn)
      done |-> (unip_r ? (fif.wdata[15:12] == 4'h0) : (fif.wdata[15:11] == {5{~i_adc_data[SIGN_BIT]}}));
  endproperty
  a_format: assert property (p_format) else $error("result format wrong");

  property p_status_word;
    @(posedge i_clk) disable iff (!i_rstn)
      (rd && (i_wb_adr == OFS_STATUS)) |=> (o_wb_ack && (o_wb_dat[31:16] == 16'h0000));
  endproperty
  a_status_word: assert property (p_status_word) else $error("status read not one 16-bit word");

  property p_pop_oldest;
    @(posedge i_clk) disable iff (!i_rstn)
      (fif.pop && !fif.empty) |=> (o_wb_dat[15:0] == $past(fif.rdata));
  endproperty
  a_pop_oldest: assert property (p_pop_oldest) else $error("fifo read did not return oldest result");

  property p_last_pop;
    @(posedge i_clk) disable iff (!i_rstn)
      (fif.pop && (fif.count == 1) && !fif.push && !clr) |=> !status[ST_NOT_EMPTY];
  endproperty
  a_last_pop: assert property (p_last_pop) else $error("fifo_not_empty stayed after last read");

  property p_overrun_no_start;
    @(posedge i_clk) disable iff (!i_rstn)
      (start && busy) |=> !o_adc_start;
  endproperty
  a_overrun_no_start: assert property (p_overrun_no_start) else $error("start accepted while busy");
endmodule : adc_fifo_ctrl
`default_nettype wire

// [logic/adc_ctrl_pkg.sv]
// constants shared by the conversion and result fifo control logic
`default_nettype none
package adc_ctrl_pkg;
  // timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CONV_TIME_NS = 5000;
  localparam int unsigned CONV_CYCLES = (CONV_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;
  // widths and depth
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned SAMPLE_W = 12;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned FIFO_DEPTH = 256;
  // register byte offsets
  localparam logic [7:0] OFS_MUX_ENTRY = 8'h00;
  localparam logic [7:0] OFS_MUX_LOAD = 8'h04;
  localparam logic [7:0] OFS_MUX_CLEAR = 8'h08;
  localparam logic [7:0] OFS_SW_CONVERT = 8'h0c;
  localparam logic [7:0] OFS_ADC_CLEAR = 8'h10;
  localparam logic [7:0] OFS_CONFIG = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_FIFO_DATA = 8'h1c;
  // field positions
  localparam int unsigned CHAN_HI = 7;
  localparam int unsigned CHAN_LO = 4;
  localparam int unsigned GAIN_HI = 3;
  localparam int unsigned GAIN_LO = 1;
  localparam int unsigned CFG_UNIPOLAR = 0;
  localparam int unsigned ST_NOT_EMPTY = 13;
  localparam int unsigned ST_OVERFLOW_N = 12;
  localparam int unsigned ST_OVERRUN_N = 11;
  localparam int unsigned ST_ACQ_DONE = 10;
  localparam int unsigned ST_BUSY = 9;
  localparam int unsigned SIGN_BIT = 11;
  // reset values
  localparam logic [7:0] MUX_RST = 8'h00;
  localparam logic CFG_UNIPOLAR_RST = 1'b0;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
endpackage : adc_ctrl_pkg
`default_nettype wire

// [logic/result_fifo_if.sv]
// signals between the control top and its result fifo
`timescale 1ns/1ps
`default_nettype none
interface result_fifo_if #(parameter int unsigned W = 16, parameter int unsigned DEPTH = 256);
  logic push;
  logic [W-1:0] wdata;
  logic pop;
  logic clear;
  logic [W-1:0] rdata;
  logic empty;
  logic full;
  logic [$clog2(DEPTH):0] count;
  modport owner (output push, wdata, pop, clear, input rdata, empty, full, count);
  modport store (input push, wdata, pop, clear, output rdata, empty, full, count);
endinterface : result_fifo_if
`default_nettype wire

// [logic/result_fifo.sv]
// flip-flop result fifo with clear
`timescale 1ns/1ps
`default_nettype none
module result_fifo #(
  parameter int unsigned W = 16,
  parameter int unsigned DEPTH = 256
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // fifo port
  result_fifo_if.store f
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = DEPTH[AW:0];
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic do_push, do_pop;

  always_comb begin
    do_pop = f.pop && (cnt_r != '0) && !f.clear;
    do_push = f.push && (f.clear || (cnt_r != DEPTH_C) || do_pop);
    wr_nxt = wr_r;
    rd_nxt = rd_r;
    cnt_nxt = cnt_r;
    if (f.clear) begin
      wr_nxt = do_push ? AW'(1) : '0;
      rd_nxt = '0;
      cnt_nxt = do_push ? (AW + 1)'(1) : '0;
    end else begin
      if (do_push) begin
        wr_nxt = wr_r + AW'(1);
      end
      if (do_pop) begin
        rd_nxt = rd_r + AW'(1);
      end
      cnt_nxt = cnt_r + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (do_push) begin
      mem[f.clear ? '0 : wr_r] <= f.wdata;
    end
  end

  assign f.rdata = mem[rd_r];
  assign f.empty = (cnt_r == '0);
  assign f.full = (cnt_r == DEPTH_C);
  assign f.count = cnt_r;

  property p_full_push_drops;
    @(posedge i_clk) disable iff (!i_rstn)
      (f.full && f.push && !f.pop && !f.clear) |=> (cnt_r == DEPTH_C);
  endproperty
  a_full_push_drops: assert property (p_full_push_drops) else $error("push into full fifo changed count");

  property p_clear_empties;
    @(posedge i_clk) disable iff (!i_rstn)
      (f.clear && !f.push) |=> (cnt_r == '0);
  endproperty
  a_clear_empties: assert property (p_clear_empties) else $error("clear did not empty fifo");
endmodule : result_fifo
`default_nettype wire

// [logic/conv_sequencer.sv]
// tracks one conversion cycle and reports completion and overrun
`timescale 1ns/1ps
`default_nettype none
module conv_sequencer #(
  parameter int unsigned CYCLES = 125
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // control
  input wire logic i_start,
  output logic o_busy,
  output logic o_done,
  output logic o_overrun
);
  typedef enum logic [0:0] {S_IDLE, S_BUSY} conv_state_t;
  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  conv_state_t state_r, state_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    o_done = 1'b0;
    o_overrun = 1'b0;
    unique case (state_r)
      S_IDLE: begin
        if (i_start) begin
          state_nxt = S_BUSY;
          cnt_nxt = '0;
        end
      end
      S_BUSY: begin
        o_overrun = i_start;
        if (cnt_r == LAST) begin
          o_done = 1'b1;
          state_nxt = S_IDLE;
        end else begin
          cnt_nxt = cnt_r + CW'(1);
        end
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state_r <= S_IDLE;
      cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign o_busy = (state_r == S_BUSY);

  property p_one_done_per_start;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_start && !o_busy) |=> (!o_done) [*4];
  endproperty
  a_one_done_per_start: assert property (p_one_done_per_start) else $error("conversion ended too early");
endmodule : conv_sequencer
`default_nettype wire

// [logic/unused_placeholder_none.sv]
// intentionally empty module-free file kept out

// [bench/adc_model.sv]
// converter model answering each accepted start with a held code
`timescale 1ns/1ps
`default_nettype none
module adc_model #(
  parameter int unsigned CYC = 8
) (
  // clock
  input wire logic i_clk,
  // control from the block
  input wire logic i_start,
  input wire logic [11:0] i_code,
  // converter output
  output logic [11:0] o_data
);
  int unsigned cnt_r = 0;
  logic [11:0] last_r = 12'h000;
  always_ff @(posedge i_clk) begin
    if (i_start) begin
      cnt_r <= CYC + 1;
      last_r <= i_code;
    end else if (cnt_r != 0) begin
      cnt_r <= cnt_r - 1;
    end
  end
  // code stands through the conversion, inverted once it is over
  assign o_data = (cnt_r != 0) ? last_r : ~last_r;
endmodule : adc_model
`default_nettype wire

// [bench/test_adc_fifo_ctrl.sv]
// self-checking bench for the conversion and result fifo control
`timescale 1ns/1ps
`default_nettype none
module test_adc_fifo_ctrl;
  import adc_ctrl_pkg::*;
  typedef struct {logic unip; logic [11:0] code; logic [15:0] word;} row_t;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic ext_n = 1'b1;
  logic [11:0] code = 12'h000;
  logic [11:0] adc_data;
  logic [31:0] o_wb_dat;
  logic o_wb_ack;
  logic adc_start;
  logic [3:0] chan;
  logic [2:0] gain;
  logic [31:0] rd;
  int error_cnt = 0;
  int compares = 0;
  int starts = 0;
  int st0 = 0;
  row_t rows[5] = '{'{1'b1, 12'h000, 16'h0000}, '{1'b1, 12'hfff, 16'h0fff}, '{1'b0, 12'h000, 16'hf800},
                    '{1'b0, 12'hfff, 16'h07ff}, '{1'b0, 12'h400, 16'hfc00}};

  always #20 i_clk = ~i_clk;

  always @(posedge i_clk) begin
    if (adc_start === 1'b1) begin
      starts++;
    end
  end

  adc_fifo_ctrl #(.DEPTH(4), .CONV_CYC(8)) i_adc_fifo_ctrl (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_dat(wdat), .i_wb_sel(4'hf), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_ext_convert_n(ext_n),
    .i_adc_data(adc_data), .o_adc_start(adc_start), .o_adc_channel(chan), .o_adc_gain(gain));
  adc_model #(.CYC(8)) i_adc_model (.i_clk(i_clk), .i_start(adc_start), .i_code(code), .o_data(adc_data));

  task automatic close_out();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 20);
    rd = o_wb_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) begin
      error_cnt++;
      close_out();
    end
  endtask : wb

  task automatic wait_done();
    int n;
    n = 0;
    do begin
      wb(1'b0, OFS_STATUS, 32'h0000_0000);
      n++;
    end while ((rd[ST_BUSY] !== 1'b0 || rd[ST_NOT_EMPTY] !== 1'b1) && n < 40);
    if (n >= 40) begin
      error_cnt++;
      close_out();
    end
  endtask : wait_done

  initial begin
    repeat (5) @(posedge i_clk);
    i_rstn <= 1'b1;
    wb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_1800);
    wb(1'b0, OFS_CONFIG, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    wb(1'b1, OFS_SW_CONVERT, 32'h0000_0001);
    wb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_1800);
    wb(1'b0, OFS_FIFO_DATA, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    wb(1'b1, 8'h40, 32'h0000_00ff);
    wb(1'b0, 8'h40, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    wb(1'b1, OFS_MUX_CLEAR, 32'h0000_0000);
    wb(1'b1, OFS_MUX_ENTRY, 32'h0000_00a6);
    wb(1'b1, OFS_MUX_LOAD, 32'h0000_0000);
    @(posedge i_clk);
    chk({28'h0, chan}, 32'h0000_000a);
    chk({29'h0, gain}, 32'h0000_0003);
    wb(1'b1, OFS_ADC_CLEAR, 32'h0000_0000);
    foreach (rows[i]) begin
      wb(1'b1, OFS_CONFIG, {31'h0, rows[i].unip});
      code <= rows[i].code;
      wb(1'b1, OFS_SW_CONVERT, 32'h0000_0000);
      wait_done();
      wb(1'b0, OFS_FIFO_DATA, 32'h0000_0000);
      chk(rd, {16'h0, rows[i].word});
      wb(1'b0, OFS_STATUS, 32'h0000_0000);
      chk(rd, 32'h0000_1c00);
    end
    chk({25'h0, chan, gain}, 32'h0000_0053);
    wb(1'b1, OFS_MUX_CLEAR, 32'h0000_0000);
    wb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk({25'h0, chan, gain}, 32'h0000_0000);
    wb(1'b1, OFS_CONFIG, 32'h0000_0001);
    code <= 12'h123;
    @(posedge i_clk);
    ext_n <= 1'b0;
    @(posedge i_clk);
    ext_n <= 1'b1;
    wait_done();
    wb(1'b0, OFS_FIFO_DATA, 32'h0000_0000);
    chk(rd, 32'h0000_0123);
    st0 = starts;
    wb(1'b1, OFS_SW_CONVERT, 32'h0000_0000);
    wb(1'b1, OFS_SW_CONVERT, 32'h0000_0000);
    wait_done();
    chk(rd, 32'h0000_3400);
    chk(starts - st0, 32'h0000_0001);
    wb(1'b0, OFS_FIFO_DATA, 32'h0000_0000);
    wb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_1400);
    wb(1'b1, OFS_ADC_CLEAR, 32'h0000_0000);
    wb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_1800);
    repeat (5) begin
      wb(1'b1, OFS_SW_CONVERT, 32'h0000_0000);
      wait_done();
    end
    chk(rd, 32'h0000_2c00);
    repeat (4) wb(1'b0, OFS_FIFO_DATA, 32'h0000_0000);
    chk(rd, 32'h0000_0123);
    wb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0c00);
    wb(1'b1, OFS_SW_CONVERT, 32'h0000_0000);
    wait_done();
    wb(1'b1, OFS_ADC_CLEAR, 32'h0000_0000);
    wb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_1800);
    wb(1'b1, OFS_SW_CONVERT, 32'h0000_0000);
    i_rstn <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_rstn <= 1'b1;
    repeat (12) @(posedge i_clk);
    wb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_1800);
    wb(1'b0, OFS_CONFIG, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    close_out();
  end
endmodule : test_adc_fifo_ctrl
`default_nettype wire
